// ---- hw/aiss_ctrl_reg.sv ----
// one write-only control word with reload to its reset value
`timescale 1ns/1ps
`default_nettype none

module aiss_ctrl_reg #(
  parameter int              W         = 10,
  parameter logic [W-1:0]    RESET_VAL = '0
) (
  input  wire logic         core_clk,
  input  wire logic         srst,
  input  wire logic         reload,
  input  wire logic         wrEn,
  input  wire logic [W-1:0] wrData,
  output var  logic [W-1:0] value
);

  logic [W-1:0] value_reg;
  logic [W-1:0] value_next;

  initial
  begin
    if (W < 1)
    begin
      $error("aiss_ctrl_reg: width must be at least one bit");
    end
  end

  // reload beats a write in the same cycle
  always_comb
  begin
    value_next = value_reg;
    if (reload)
    begin
      value_next = RESET_VAL;
    end
    else if (wrEn)
    begin
      value_next = wrData;
    end
  end

  // storage
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      value_reg <= RESET_VAL;
    end
    else
    begin
      value_reg <= value_next;
    end
  end

  assign value = value_reg;

endmodule

`default_nettype wire

// ---- hw/aiss_defines.svh ----
// offsets, field positions, reset values and widths of the scan select block
`ifndef AISS_DEFINES_SVH
`define AISS_DEFINES_SVH

// register addresses on the two register-select lines {hi, lo}
`define AISS_ADDR_CTRL0      2'h0
`define AISS_ADDR_CTRL1      2'h1

// control word width and reset values
`define AISS_CTRL_W          10
`define AISS_CTRL0_RESET     10'h020
`define AISS_CTRL1_RESET     10'h030

// first control register fields
`define AISS_C0_REF_EXT      0
`define AISS_C0_SINGLE       1
`define AISS_C0_PWRDN        2
`define AISS_C0_SEL_LSB      3
`define AISS_C0_SEL_MSB      7
`define AISS_C0_TEST_LSB     8
`define AISS_C0_TEST_MSB     9

// second control register fields
`define AISS_C1_RESET        0
`define AISS_C1_QCLR         1
`define AISS_C1_FILL_LSB     2
`define AISS_C1_FILL_MSB     3
`define AISS_C1_FLAG_TYPE    4
`define AISS_C1_FLAG_POL     5
`define AISS_C1_RW_MODE      6
`define AISS_C1_FORMAT       7
`define AISS_C1_OFFSET       8

// autoscan sequence geometry
`define AISS_MAX_STEPS       4
`define AISS_STEP_W          2

`endif

// ---- hw/aiss_pkg.sv ----
// types shared by the scan select block
package aiss_pkg;

  // five-bit selection code: {autoscan, diff_count_hi, diff_count_lo, input_pick_hi, input_pick_lo}
  typedef enum logic [4:0] {
    SEL_SE_APOS       = 5'h00,
    SEL_SE_ANEG       = 5'h01,
    SEL_SE_BPOS       = 5'h02,
    SEL_SE_BNEG       = 5'h03,
    SEL_DIFF_A        = 5'h04,
    SEL_DIFF_B        = 5'h05,
    SEL_SCAN2         = 5'h11,
    SEL_SCAN3         = 5'h12,
    SEL_SCAN4         = 5'h13,
    SEL_SCAN_SE_DIFF  = 5'h15,
    SEL_SCAN_2SE_DIFF = 5'h16,
    SEL_SCAN_2DIFF    = 5'h19
  } aiss_sel_e;

  // source actually fed to the converter
  typedef enum logic [3:0] {
    SRC_A_POS     = 4'h0,
    SRC_A_NEG     = 4'h1,
    SRC_B_POS     = 4'h2,
    SRC_B_NEG     = 4'h3,
    SRC_DIFF_A    = 4'h4,
    SRC_DIFF_B    = 4'h5,
    SRC_UPPER_REF = 4'h6,
    SRC_MID_REF   = 4'h7,
    SRC_LOWER_REF = 4'h8,
    SRC_NONE      = 4'hF
  } aiss_src_e;

  // self-test selection
  typedef enum logic [1:0] {
    TEST_OFF   = 2'h0,
    TEST_UPPER = 2'h1,
    TEST_MID   = 2'h2,
    TEST_LOWER = 2'h3
  } aiss_test_e;

endpackage

// ---- hw/aiss_scan_seq.sv ----
// autoscan step counter, wraps after the last step
`timescale 1ns/1ps
`default_nettype none

module aiss_scan_seq #(
  parameter int MAX_STEPS = 4,
  parameter int IDX_W     = 2
) (
  input  wire logic             core_clk,
  input  wire logic             srst,
  input  wire logic             restart,
  input  wire logic             advance,
  input  wire logic [IDX_W-1:0] lastIdx,
  output var  logic [IDX_W-1:0] stepIdx
);

  logic [IDX_W-1:0] step_reg;
  logic [IDX_W-1:0] step_next;

  initial
  begin
    if (MAX_STEPS < 1 || MAX_STEPS > (1 << IDX_W))
    begin
      $error("aiss_scan_seq: step count does not fit the index width");
    end
  end

  // restart wins over advance; wrap to the first entry after the last
  always_comb
  begin
    step_next = step_reg;
    if (restart)
    begin
      step_next = '0;
    end
    else if (advance)
    begin
      step_next = (step_reg >= lastIdx) ? '0 : step_reg + 1'b1;
    end
  end

  // step register
  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      step_reg <= '0;
    end
    else
    begin
      step_reg <= step_next;
    end
  end

  assign stepIdx = step_reg;

endmodule

`default_nettype wire

// ---- hw/aiss_top.sv ----
// input selection, autoscan order, self-test and control register decode
//
// Overview of operation
// - The five-bit selection code is taken from bits 3 to 7 of the first control word.
// - Scan and diff count clear: one single-ended input picked by the two pick bits.
// - Scan clear, only diff_count_lo set: pick 00 is pair A differential, 01 is pair B.
// - Scan, diff 00, pick 01: repeat pair_a_pos then pair_a_neg.
// - Scan, diff 00, pick 10: repeat pair_a_pos, pair_a_neg, pair_b_pos.
// - Scan, diff 00, pick 11: repeat all four single-ended inputs in order.
// - Scan, diff 01, pick 01: alternate pair_a_pos and the pair B differential.
// - Scan, diff 01, pick 10: repeat pair_a_pos, pair_a_neg, then pair B differential.
// - Scan, diff 10, pick 01: alternate pair A and pair B differentials.
// - Test bits 9:8 pick normal, upper reference, midpoint, or lower reference.
// - The second control word is write-only at register select hi 0, lo 1.
// - Any test selection disables the result-ready flag until reinitialisation.
`timescale 1ns/1ps
`default_nettype none
`include "aiss_defines.svh"

module aiss_top #(
  parameter int CTRL_W    = `AISS_CTRL_W,
  parameter int MAX_STEPS = `AISS_MAX_STEPS
) (
  input  wire logic                  core_clk,
  input  wire logic                  srst,
  input  wire logic                  reg_sel_hi,
  input  wire logic                  reg_sel_lo,
  input  wire logic                  chipSelN,
  input  wire logic                  writeN,
  input  wire logic [CTRL_W-1:0]     dataIn,
  input  wire logic                  convStrobe,
  output var  aiss_pkg::aiss_src_e   inputSource,
  output logic                       sourceValid,
  output logic [`AISS_STEP_W-1:0]    scanStep,
  output logic                       reservedSel,
  output logic                       testActive,
  output logic                       resultReadyEnable,
  output logic                       refSelectExt,
  output logic                       singleShotMode,
  output logic                       powerDown,
  output logic [1:0]                 fillLevel,
  output logic                       flagIsPulse,
  output logic                       flagActiveHigh,
  output logic                       rwPinMode,
  output logic                       output_format_sel,
  output logic                       offsetEnable,
  output logic                       queueClearPulse,
  output logic                       deviceResetPulse
);

  initial
  begin
    if (CTRL_W != `AISS_CTRL_W)
    begin
      $error("aiss_top: control word width must be ten bits");
    end
    if (MAX_STEPS != `AISS_MAX_STEPS)
    begin
      $error("aiss_top: autoscan tables hold exactly four steps");
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // parallel port write decode

  logic                    writePrev_reg;
  logic                    writePrev_next;
  logic                    wrTaken;
  logic [1:0]              regAddr;
  logic                    wrCtrl0;
  logic                    wrCtrl1;
  logic                    initReq;
  logic                    qclrReq;
  logic [CTRL_W-1:0]       ctrl0;
  logic [CTRL_W-1:0]       ctrl1;
  logic [CTRL_W-1:0]       ctrl1Data;

  // a write is taken once, on the falling edge of the write strobe
  always_comb
  begin
    writePrev_next = writeN;
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      writePrev_reg <= 1'b1;
    end
    else
    begin
      writePrev_reg <= writePrev_next;
    end
  end

  // address from the two select lines, reset and queue clear self-clear
  assign wrTaken   = !chipSelN && !writeN && writePrev_reg;
  assign regAddr   = {reg_sel_hi, reg_sel_lo};
  assign wrCtrl0   = wrTaken && (regAddr == `AISS_ADDR_CTRL0);
  assign wrCtrl1   = wrTaken && (regAddr == `AISS_ADDR_CTRL1);
  assign initReq   = wrCtrl1 && dataIn[`AISS_C1_RESET];
  assign qclrReq   = wrCtrl1 && dataIn[`AISS_C1_QCLR];
  assign ctrl1Data = dataIn & ~(CTRL_W'(1) << `AISS_C1_QCLR);

  // first control word
  aiss_ctrl_reg #(
    .W         (CTRL_W),
    .RESET_VAL (CTRL_W'(`AISS_CTRL0_RESET))
  ) u_ctrl0 (
    .core_clk (core_clk),
    .srst     (srst),
    .reload   (initReq),
    .wrEn     (wrCtrl0),
    .wrData   (dataIn),
    .value    (ctrl0)
  );

  // second control word, write-only from the port
  aiss_ctrl_reg #(
    .W         (CTRL_W),
    .RESET_VAL (CTRL_W'(`AISS_CTRL1_RESET))
  ) u_ctrl1 (
    .core_clk (core_clk),
    .srst     (srst),
    .reload   (initReq),
    .wrEn     (wrCtrl1),
    .wrData   (ctrl1Data),
    .value    (ctrl1)
  );

  //////////////////////////////////////////////////////////////////////////////
  // selection decode

  logic [4:0]              selCode;
  logic                    selLegal;
  logic [`AISS_STEP_W-1:0] lastIdx;
  aiss_pkg::aiss_test_e    testSel;
  logic [`AISS_STEP_W-1:0] stepIdx;

  assign selCode = ctrl0[`AISS_C0_SEL_MSB:`AISS_C0_SEL_LSB];
  assign testSel = aiss_pkg::aiss_test_e'(ctrl0[`AISS_C0_TEST_MSB:`AISS_C0_TEST_LSB]);

  // legality and last step of each code
  always_comb
  begin
    selLegal = 1'b1;
    lastIdx  = 2'h0;
    unique case (selCode)
      aiss_pkg::SEL_SE_APOS, aiss_pkg::SEL_SE_ANEG,
      aiss_pkg::SEL_SE_BPOS, aiss_pkg::SEL_SE_BNEG,
      aiss_pkg::SEL_DIFF_A,  aiss_pkg::SEL_DIFF_B:        lastIdx = 2'h0;
      aiss_pkg::SEL_SCAN2:                                lastIdx = 2'h1;
      aiss_pkg::SEL_SCAN3:                                lastIdx = 2'h2;
      aiss_pkg::SEL_SCAN4:                                lastIdx = 2'h3;
      aiss_pkg::SEL_SCAN_SE_DIFF:                         lastIdx = 2'h1;
      aiss_pkg::SEL_SCAN_2SE_DIFF:                        lastIdx = 2'h2;
      aiss_pkg::SEL_SCAN_2DIFF:                           lastIdx = 2'h1;
      default:                                            selLegal = 1'b0;
    endcase
  end

  // source for a given code and step
  function automatic aiss_pkg::aiss_src_e entryFor(input logic [4:0]              code,
                                                   input logic [`AISS_STEP_W-1:0] idx);
    aiss_pkg::aiss_src_e src;
    src = aiss_pkg::SRC_NONE;
    unique case (code)
      aiss_pkg::SEL_SE_APOS:   src = aiss_pkg::SRC_A_POS;
      aiss_pkg::SEL_SE_ANEG:   src = aiss_pkg::SRC_A_NEG;
      aiss_pkg::SEL_SE_BPOS:   src = aiss_pkg::SRC_B_POS;
      aiss_pkg::SEL_SE_BNEG:   src = aiss_pkg::SRC_B_NEG;
      aiss_pkg::SEL_DIFF_A:    src = aiss_pkg::SRC_DIFF_A;
      aiss_pkg::SEL_DIFF_B:    src = aiss_pkg::SRC_DIFF_B;
      aiss_pkg::SEL_SCAN2,
      aiss_pkg::SEL_SCAN3,
      aiss_pkg::SEL_SCAN4:
        src = aiss_pkg::aiss_src_e'({2'h0, idx});
      aiss_pkg::SEL_SCAN_SE_DIFF:
        src = (idx == 2'h0) ? aiss_pkg::SRC_A_POS : aiss_pkg::SRC_DIFF_B;
      aiss_pkg::SEL_SCAN_2SE_DIFF:
      begin
        if (idx == 2'h0)
        begin
          src = aiss_pkg::SRC_A_POS;
        end
        else if (idx == 2'h1)
        begin
          src = aiss_pkg::SRC_A_NEG;
        end
        else
        begin
          src = aiss_pkg::SRC_DIFF_B;
        end
      end
      aiss_pkg::SEL_SCAN_2DIFF:
        src = (idx == 2'h0) ? aiss_pkg::SRC_DIFF_A : aiss_pkg::SRC_DIFF_B;
      default:                 src = aiss_pkg::SRC_NONE;
    endcase
    return src;
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // autoscan stepping

  logic seqAdvance;
  logic seqRestart;

  // restart on a write to the first control word or a reinit, step once per normal conversion
  assign seqRestart = wrCtrl0 || initReq;
  assign seqAdvance = convStrobe && selLegal && (testSel == aiss_pkg::TEST_OFF);

  aiss_scan_seq #(
    .MAX_STEPS (MAX_STEPS),
    .IDX_W     (`AISS_STEP_W)
  ) u_seq (
    .core_clk (core_clk),
    .srst     (srst),
    .restart  (seqRestart),
    .advance  (seqAdvance),
    .lastIdx  (lastIdx),
    .stepIdx  (stepIdx)
  );

  //////////////////////////////////////////////////////////////////////////////
  // conversion source and test latch

  aiss_pkg::aiss_src_e source_reg;
  aiss_pkg::aiss_src_e source_next;
  logic                valid_reg;
  logic                valid_next;
  logic                testSeen_reg;
  logic                testSeen_next;

  // test voltage overrides the scan table; a test sticks until reinit
  always_comb
  begin
    source_next   = source_reg;
    valid_next    = 1'b0;
    testSeen_next = testSeen_reg;
    if (testSel != aiss_pkg::TEST_OFF)
    begin
      testSeen_next = 1'b1;
    end
    if (initReq)
    begin
      testSeen_next = 1'b0;
    end
    if (convStrobe)
    begin
      valid_next = 1'b1;
      unique case (testSel)
        aiss_pkg::TEST_UPPER: source_next = aiss_pkg::SRC_UPPER_REF;
        aiss_pkg::TEST_MID:   source_next = aiss_pkg::SRC_MID_REF;
        aiss_pkg::TEST_LOWER: source_next = aiss_pkg::SRC_LOWER_REF;
        aiss_pkg::TEST_OFF:   source_next = entryFor(selCode, stepIdx);
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      source_reg   <= aiss_pkg::SRC_NONE;
      valid_reg    <= 1'b0;
      testSeen_reg <= 1'b0;
    end
    else
    begin
      source_reg   <= source_next;
      valid_reg    <= valid_next;
      testSeen_reg <= testSeen_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // registered status and control outputs

  logic [CTRL_W-1:0] cfgOut_reg;
  logic [CTRL_W-1:0] cfgOut_next;
  logic [CTRL_W-1:0] c0Out_reg;
  logic [CTRL_W-1:0] c0Out_next;
  logic [3:0]        stat_reg;
  logic [3:0]        stat_next;
  logic [1:0]        pulse_reg;
  logic [1:0]        pulse_next;

  // status: spare zero bit, reserved code, test active, flag gate
  always_comb
  begin
    cfgOut_next = ctrl1;
    c0Out_next  = ctrl0;
    // flag gate also held low while the old test bits stand during a reinit
    stat_next   = {!testSeen_next && (testSel == aiss_pkg::TEST_OFF),
                   testSel != aiss_pkg::TEST_OFF, !selLegal, 1'b0};
    pulse_next  = {initReq, qclrReq || initReq};
  end

  always_ff @(posedge core_clk)
  begin
    if (srst)
    begin
      cfgOut_reg <= CTRL_W'(`AISS_CTRL1_RESET);
      c0Out_reg  <= CTRL_W'(`AISS_CTRL0_RESET);
      stat_reg   <= 4'h8;
      pulse_reg  <= 2'h0;
    end
    else
    begin
      cfgOut_reg <= cfgOut_next;
      c0Out_reg  <= c0Out_next;
      stat_reg   <= stat_next;
      pulse_reg  <= pulse_next;
    end
  end

  assign inputSource       = source_reg;
  assign sourceValid       = valid_reg;
  assign scanStep          = stepIdx;
  assign reservedSel       = stat_reg[1];
  assign testActive        = stat_reg[2];
  assign resultReadyEnable = stat_reg[3];
  assign refSelectExt      = c0Out_reg[`AISS_C0_REF_EXT];
  assign singleShotMode    = c0Out_reg[`AISS_C0_SINGLE];
  assign powerDown         = c0Out_reg[`AISS_C0_PWRDN];
  assign fillLevel         = cfgOut_reg[`AISS_C1_FILL_MSB:`AISS_C1_FILL_LSB];
  assign flagIsPulse       = cfgOut_reg[`AISS_C1_FLAG_TYPE];
  assign flagActiveHigh    = cfgOut_reg[`AISS_C1_FLAG_POL];
  assign rwPinMode         = cfgOut_reg[`AISS_C1_RW_MODE];
  assign output_format_sel = cfgOut_reg[`AISS_C1_FORMAT];
  assign offsetEnable      = cfgOut_reg[`AISS_C1_OFFSET];
  assign queueClearPulse   = pulse_reg[0];
  assign deviceResetPulse  = pulse_reg[1];

endmodule

`default_nettype wire

// ---- tb/aiss_host_model.sv ----
// processor model driving the register write port
`timescale 1ns/1ps
`default_nettype none

module aiss_host_model (
  input  wire logic       core_clk,
  output var  logic       reg_sel_hi,
  output var  logic       reg_sel_lo,
  output var  logic       chipSelN,
  output var  logic       writeN,
  output var  logic [9:0] dataIn
);
  ////////////////////////////////////////
  // idle bus at time zero
  initial
  begin
    {reg_sel_hi, reg_sel_lo} = 2'h3;
    chipSelN = 1'b1;
    writeN = 1'b1;
    dataIn = 10'h3ff;
  end

  // one write held across the taking edge, lines scrambled once released
  task automatic wr(input logic [1:0] a, input logic [9:0] d);
    @(negedge core_clk);
    {reg_sel_hi, reg_sel_lo} = a;
    dataIn = d;
    chipSelN = 1'b0;
    writeN = 1'b0;
    @(posedge core_clk);
    @(negedge core_clk);
    chipSelN = 1'b1;
    writeN = 1'b1;
    {reg_sel_hi, reg_sel_lo} = ~a;
    dataIn = ~d;
  endtask
endmodule
`default_nettype wire

// ---- tb/aiss_top_checker.sv ----
// assertions on the ports of the scan select block
`timescale 1ns/1ps
`default_nettype none
`include "aiss_defines.svh"

module aiss_top_checker #(
  parameter int CTRL_W = `AISS_CTRL_W
) (
  input wire logic                    core_clk,
  input wire logic                    srst,
  input wire logic                    reg_sel_hi,
  input wire logic                    reg_sel_lo,
  input wire logic                    chipSelN,
  input wire logic                    writeN,
  input wire logic [CTRL_W-1:0]       dataIn,
  input wire logic                    convStrobe,
  input wire aiss_pkg::aiss_src_e     inputSource,
  input wire logic                    sourceValid,
  input wire logic [`AISS_STEP_W-1:0] scanStep,
  input wire logic                    testActive,
  input wire logic                    resultReadyEnable,
  input wire logic [1:0]              fillLevel,
  input wire logic                    flagIsPulse,
  input wire logic                    flagActiveHigh,
  input wire logic                    output_format_sel,
  input wire logic                    offsetEnable,
  input wire logic                    queueClearPulse,
  input wire logic                    deviceResetPulse
);
  ////////////////////////////////////////
  logic wrPrev;
  logic take;

  // write strobe level at the previous edge, for falling-edge detection
  always_ff @(posedge core_clk) wrPrev <= writeN;
  assign take = !chipSelN && !writeN && wrPrev;

  ////////////////////////////////////////
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);

  // accepted writes to each control word
  sequence s_wr0; take && !reg_sel_hi && !reg_sel_lo; endsequence
  sequence s_wr1; take && !reg_sel_hi && reg_sel_lo; endsequence

  a_valid_follows_strobe: assert property (sourceValid == $past(convStrobe))
    else $error("result valid not one cycle after strobe");
  a_test_gates_ready: assert property (testActive |-> !resultReadyEnable)
    else $error("ready flag allowed during test");
  a_ready_needs_reinit: assert property ($rose(resultReadyEnable) |->
    deviceResetPulse || $past(deviceResetPulse))
    else $error("ready flag returned without reinit");
  a_reset_pulse_pair: assert property (deviceResetPulse |-> queueClearPulse ##1 !deviceResetPulse)
    else $error("reset pulse shape wrong");
  a_queue_clear_cause: assert property (s_wr1 ##0 dataIn[1] |=> queueClearPulse)
    else $error("queue clear pulse missing");
  a_reinit_values: assert property (s_wr1 ##0 dataIn[0] |-> ##2
    (flagIsPulse && flagActiveHigh && fillLevel == 2'h0 && !offsetEnable))
    else $error("second word not reloaded");
  a_ctrl1_mirror: assert property (s_wr1 ##0 !dataIn[0] |-> ##2
    (fillLevel == $past(dataIn[3:2], 2) && output_format_sel == $past(dataIn[7], 2)
    && offsetEnable == $past(dataIn[8], 2)))
    else $error("second word fields not mirrored");
  a_scan_restart: assert property (s_wr0 ##1 !convStrobe |=> scanStep == 2'h0)
    else $error("scan not restarted by write");
  a_test_source: assert property (convStrobe && testActive && !$past(take) |=> inputSource inside
    {aiss_pkg::SRC_UPPER_REF, aiss_pkg::SRC_MID_REF, aiss_pkg::SRC_LOWER_REF})
    else $error("test conversion not a reference");
endmodule

bind aiss_top aiss_top_checker #(.CTRL_W(CTRL_W)) u_checker (
  .core_clk(core_clk), .srst(srst), .reg_sel_hi(reg_sel_hi), .reg_sel_lo(reg_sel_lo),
  .chipSelN(chipSelN), .writeN(writeN), .dataIn(dataIn), .convStrobe(convStrobe),
  .inputSource(inputSource), .sourceValid(sourceValid), .scanStep(scanStep),
  .testActive(testActive), .resultReadyEnable(resultReadyEnable), .fillLevel(fillLevel),
  .flagIsPulse(flagIsPulse), .flagActiveHigh(flagActiveHigh),
  .output_format_sel(output_format_sel), .offsetEnable(offsetEnable),
  .queueClearPulse(queueClearPulse), .deviceResetPulse(deviceResetPulse)
);
`default_nettype wire

// ---- tb/aiss_top_tb.sv ----
// self-checking bench for the scan select block
`timescale 1ns/1ps
`default_nettype none
`include "aiss_defines.svh"

module aiss_top_tb;
  localparam aiss_pkg::aiss_src_e AP = aiss_pkg::SRC_A_POS;
  localparam aiss_pkg::aiss_src_e AN = aiss_pkg::SRC_A_NEG;
  localparam aiss_pkg::aiss_src_e BP = aiss_pkg::SRC_B_POS;
  localparam aiss_pkg::aiss_src_e DA = aiss_pkg::SRC_DIFF_A;
  localparam aiss_pkg::aiss_src_e DB = aiss_pkg::SRC_DIFF_B;
  logic                core_clk, srst, convStrobe, reg_sel_hi, reg_sel_lo, chipSelN, writeN;
  logic [9:0]          dataIn;
  aiss_pkg::aiss_src_e inputSource;
  logic [1:0]          scanStep, fillLevel;
  logic                sourceValid, reservedSel, testActive, resultReadyEnable, refSelectExt;
  logic                singleShotMode, powerDown, flagIsPulse, flagActiveHigh, rwPinMode;
  logic                output_format_sel, offsetEnable, queueClearPulse, deviceResetPulse;
  int                  n_mismatch = 0;
  int                  comparisons = 0;
  int                  cycles = 0;

  ////////////////////////////////////////
  aiss_host_model host (.core_clk(core_clk), .reg_sel_hi(reg_sel_hi), .reg_sel_lo(reg_sel_lo),
    .chipSelN(chipSelN), .writeN(writeN), .dataIn(dataIn));
  aiss_top dut (.core_clk(core_clk), .srst(srst), .reg_sel_hi(reg_sel_hi),
    .reg_sel_lo(reg_sel_lo), .chipSelN(chipSelN), .writeN(writeN), .dataIn(dataIn),
    .convStrobe(convStrobe), .inputSource(inputSource), .sourceValid(sourceValid),
    .scanStep(scanStep), .reservedSel(reservedSel), .testActive(testActive),
    .resultReadyEnable(resultReadyEnable), .refSelectExt(refSelectExt),
    .singleShotMode(singleShotMode), .powerDown(powerDown), .fillLevel(fillLevel),
    .flagIsPulse(flagIsPulse), .flagActiveHigh(flagActiveHigh), .rwPinMode(rwPinMode),
    .output_format_sel(output_format_sel), .offsetEnable(offsetEnable),
    .queueClearPulse(queueClearPulse), .deviceResetPulse(deviceResetPulse));

  ////////////////////////////////////////
  // clock and hang guard
  initial
  begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      n_mismatch++;
      test_done();
    end
  end

  ////////////////////////////////////////
  // compares, waits and conversion runs
  task automatic chk_val(input string what, input logic [3:0] exp, input logic [3:0] got);
    comparisons++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_src(input string what, input aiss_pkg::aiss_src_e exp,
                         input aiss_pkg::aiss_src_e got);
    chk_val(what, exp, got);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  task automatic conv_run(input aiss_pkg::aiss_src_e seq [4], input int len, input int n);
    convStrobe = 1'b1;
    for (int i = 0; i < n; i++)
    begin
      @(negedge core_clk);
      if (i == n - 1) convStrobe = 1'b0;
      chk_val("result valid", 4'h1, {3'h0, sourceValid});
      chk_src("source", seq[i % len], inputSource);
      chk_val("scan step", 4'((i + 1) % len), {2'h0, scanStep});
    end
  endtask
  task automatic conv1(input aiss_pkg::aiss_src_e exp);
    conv_run('{exp, exp, exp, exp}, 1, 1);
  endtask

  ////////////////////////////////////////
  // scenarios
  task automatic t_reset;
    chk_src("source at reset", aiss_pkg::SRC_NONE, inputSource);
    chk_val("ready at reset", 4'h1, {3'h0, resultReadyEnable});
    chk_val("flag shape at reset", 4'h3, {fillLevel, flagActiveHigh, flagIsPulse});
    conv1(DA);
    $display("test reset done");
  endtask
  task automatic t_single;
    aiss_pkg::aiss_src_e exp [6] = '{AP, AN, BP, aiss_pkg::SRC_B_NEG, DA, DB};
    for (int c = 0; c < 6; c++)
    begin
      host.wr(2'h0, {2'h0, c[4:0], c[2:0]});
      cyc(1);
      chk_val("low ctrl bits", {1'b0, c[2:0]}, {1'b0, powerDown, singleShotMode, refSelectExt});
      conv1(exp[c]);
    end
    $display("test single done");
  endtask
  task automatic t_scan;
    logic [4:0] code [6] = '{5'h11, 5'h12, 5'h13, 5'h15, 5'h16, 5'h19};
    int len [6] = '{2, 3, 4, 2, 3, 2};
    aiss_pkg::aiss_src_e seq [6][4] = '{'{AP, AN, AP, AP}, '{AP, AN, BP, AP},
      '{AP, AN, BP, aiss_pkg::SRC_B_NEG}, '{AP, DB, AP, AP}, '{AP, AN, DB, AP}, '{DA, DB, DA, DA}};
    for (int r = 0; r < 6; r++)
    begin
      host.wr(2'h0, {2'h0, code[r], 3'h0});
      cyc(1);
      conv_run(seq[r], len[r], 2 * len[r] + 1);
    end
    $display("test scan done");
  endtask
  task automatic t_reserved;
    host.wr(2'h0, {2'h0, 5'h06, 3'h0});
    cyc(1);
    conv1(aiss_pkg::SRC_NONE);
    chk_val("reserved flag", 4'h1, {3'h0, reservedSel});
    $display("test reserved done");
  endtask
  task automatic t_test;
    aiss_pkg::aiss_src_e refs [4] = '{AP, aiss_pkg::SRC_UPPER_REF, aiss_pkg::SRC_MID_REF,
                                     aiss_pkg::SRC_LOWER_REF};
    for (int t = 1; t < 4; t++)
    begin
      host.wr(2'h0, {t[1:0], 8'h00});
      cyc(1);
      chk_val("test and ready", 4'h2, {2'h0, testActive, resultReadyEnable});
      conv1(refs[t]);
    end
    host.wr(2'h0, 10'h000);
    cyc(2);
    chk_val("ready after test off", 4'h0, {3'h0, resultReadyEnable});
    conv1(AP);
    host.wr(2'h1, 10'h001);
    chk_val("reset pulses", 4'h3, {2'h0, deviceResetPulse, queueClearPulse});
    cyc(2);
    chk_val("ready after reinit", 4'h1, {3'h0, resultReadyEnable});
    $display("test selftest done");
  endtask
  task automatic t_ctrl1;
    host.wr(2'h1, 10'h1ce);
    chk_val("queue clear only", 4'h1, {2'h0, deviceResetPulse, queueClearPulse});
    for (int a = 1; a < 4; a++)
    begin
      cyc(1);
      chk_val("fill level", 4'h3, {2'h0, fillLevel});
      chk_val("flag shape", 4'h0, {2'h0, flagActiveHigh, flagIsPulse});
      chk_val("mode bits", 4'h7, {1'h0, offsetEnable, output_format_sel, rwPinMode});
      if (a < 3) host.wr(a[1:0] + 2'h1, 10'h030);
    end
    $display("test second word done");
  endtask

  ////////////////////////////////////////
  // verdict
  task automatic test_done;
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // reset then the scenarios
  initial
  begin
    srst = 1'b1;
    convStrobe = 1'b0;
    repeat (16) @(negedge core_clk);
    srst = 1'b0;
    t_reset();
    t_single();
    t_scan();
    t_reserved();
    t_test();
    t_ctrl1();
    test_done();
  end
endmodule
`default_nettype wire
